// ---- inc/spi_fe_pkg.sv ----
// Purpose: constants and register map of the serial link front end
// Assumes: byte wide register port, address is the register offset
// Notes:   extra event and mask registers sit above the printed map
//
// Operation
// - reserved bits read zero, writes to them change nothing
// - control one at 0x0, control two at 0x1, divider at 0x2
// - status at 0x3 is read only: done bit 7, empty 5, fault 4
// - writes to status and reserved offsets are dropped
// - offsets 0x4, 0x6 and 0x7 read as zero
// - data register at 0x5, eight bits, msb in bit 7
// - irq enable lets done or fault flag raise the interrupt
// - system enable gives pins to link; clear forces idle, resets flags
// - tx empty irq enable lets the empty flag raise the interrupt
// - master select picks master or slave; any change forces idle
// - polarity zero idles clock low, one idles it high
// - phase zero samples odd edges, one samples even, of sixteen
// - master: change of polarity, phase, select enable, order aborts
// - low bit first shifts lsb first; register keeps msb in bit 7
// - master select pin: unused, fault input, or select output
// - in slave mode the select pin is always an input
// - master clock is bus clock over (preselect+1)*2^(select+1)
package spi_fe_pkg;
    localparam int          ADDR_W       = 4;
    localparam logic [3:0]  OFS_CTRL1    = 4'h0;
    localparam logic [3:0]  OFS_CTRL2    = 4'h1;
    localparam logic [3:0]  OFS_DIV      = 4'h2;
    localparam logic [3:0]  OFS_STATUS   = 4'h3;
    localparam logic [3:0]  OFS_DATA     = 4'h5;
    localparam logic [3:0]  OFS_EVENT    = 4'h8;
    localparam logic [3:0]  OFS_MASK     = 4'h9;
    // control one fields
    localparam int          B_IRQ_EN     = 7;
    localparam int          B_SYS_EN     = 6;
    localparam int          B_TXE_IRQ_EN = 5;
    localparam int          B_MASTER     = 4;
    localparam int          B_CLOCK_POLARITY       = 3;
    localparam int          B_CLOCK_PHASE       = 2;
    localparam int          B_SEL_OE     = 1;
    localparam int          B_LSB_FIRST  = 0;
    // control two fields
    localparam int          B_FAULT_EN   = 4;
    localparam logic [7:0]  CTRL2_MASK   = 8'h1b;
    localparam logic [7:0]  DIV_MASK     = 8'h77;
    localparam int          PRE_LSB      = 4;
    // status fields
    localparam int          B_DONE       = 7;
    localparam int          B_EMPTY      = 5;
    localparam int          B_FAULT      = 4;
    // event register fields
    localparam int          E_DONE       = 0;
    localparam int          E_EMPTY      = 1;
    localparam int          E_FAULT      = 2;
    localparam int          EV_W         = 3;
    // serial framing
    localparam logic [3:0]  LAST_EDGE    = 4'hf;
    localparam int          CNT_W        = 11;
    localparam logic [7:0]  RST_CTRL1    = 8'h04;
    localparam logic [7:0]  RST_CTRL2    = 8'h00;
    localparam logic [7:0]  RST_DIV      = 8'h00;
endpackage : spi_fe_pkg

// ---- rtl/spi_fe.sv ----
// Purpose: register front end and byte shifter of a serial link port
// Assumes: all pins clocked by sys_clk; pin inputs pass two flops
// Notes:   output enables are active low; one wire mode not built
//
// Added by the designer: the address-and-strobe port.
`timescale 1ns/1ps
module spi_fe
    import spi_fe_pkg::*;
(
    input  wire logic              sys_clk,
    input  wire logic              nrst,
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic [7:0]        wdata,
    input  wire logic              wr_stb,
    input  wire logic              rd_stb,
    output logic [7:0]             rdata,
    output logic                   irq,
    input  wire logic              sck_in,
    output logic                   sck_out,
    output logic                   sck_oe_n,
    input  wire logic              mosi_in,
    output logic                   mosi_out,
    output logic                   mosi_oe_n,
    input  wire logic              miso_in,
    output logic                   miso_out,
    output logic                   miso_oe_n,
    input  wire logic              sel_in,
    output logic                   sel_out,
    output logic                   sel_oe_n
);

    typedef enum logic {IDLE, RUN} phase_t;

    typedef struct packed {
        // registers
        logic [7:0]      ctrl1;
        logic [7:0]      ctrl2;
        logic [7:0]      div;

        // flags and their arming
        logic            done;
        logic            empty;
        logic            fault;
        logic            st_seen_done;
        logic            st_seen_empty;
        logic            st_seen_fault;

        // events
        logic [EV_W-1:0] ev;
        logic [EV_W-1:0] mask;

        // shifter
        logic [7:0]      tx_buf;
        logic [7:0]      tx_sh;
        logic [7:0]      rx_sh;
        logic [7:0]      rx_data;
        logic            dout;
        phase_t          ph;
        logic [3:0]      edge_cnt;
        logic [CNT_W-1:0] tick_cnt;

        // synchronisers
        logic [1:0]      sck_sy;
        logic [1:0]      mosi_sy;
        logic [1:0]      miso_sy;
        logic [1:0]      sel_sy;
        logic            sck_d;

        // pin drivers
        logic            sck_r;
        logic            sck_oe_r;
        logic            mosi_r;
        logic            mosi_oe_r;
        logic            miso_r;
        logic            miso_oe_r;
        logic            sel_r;
        logic            sel_oe_r;

        // outputs
        logic            irq_r;
        logic [7:0]      rdata_r;
    } state_t;

    state_t s_r;
    state_t s_nxt;

    // first bit of a byte for the chosen order
    function automatic logic first_bit(input logic [7:0] d, input logic lsb);
        first_bit = lsb ? d[0] : d[7];
    endfunction : first_bit

    // drop the bit just sent
    function automatic logic [7:0] shift_out(input logic [7:0] d, input logic lsb);
        shift_out = lsb ? {1'b0, d[7:1]} : {d[6:0], 1'b0};
    endfunction : shift_out

    // insert a received bit; byte ends with msb in bit 7
    function automatic logic [7:0] shift_in(input logic [7:0] d, input logic b,
                                            input logic lsb);
        shift_in = lsb ? {b, d[7:1]} : {d[6:0], b};
    endfunction : shift_in

    // control fields
    logic            sys_en;
    logic            master;
    logic            clock_polarity;
    logic            clock_phase;
    logic            lsb;
    logic            fault_en;
    logic            sel_oe;

    // clock and edge decode
    logic [CNT_W-1:0] half_per;
    logic            tick;
    logic            sck_s;
    logic            sel_s;
    logic            sl_edge;
    logic            step;
    logic            sample;
    logic            abort;
    logic            rbit;

    // port decode
    logic [7:0]      wd;
    logic            w_ctrl1;
    logic            w_data;
    logic [EV_W-1:0] ev_set;

    // decoded control bits
    assign sys_en   = s_r.ctrl1[B_SYS_EN];
    assign master   = s_r.ctrl1[B_MASTER];
    assign clock_polarity     = s_r.ctrl1[B_CLOCK_POLARITY];
    assign clock_phase     = s_r.ctrl1[B_CLOCK_PHASE];
    assign lsb      = s_r.ctrl1[B_LSB_FIRST];
    assign sel_oe   = s_r.ctrl1[B_SEL_OE];
    assign fault_en = s_r.ctrl2[B_FAULT_EN];
    assign sck_s    = s_r.sck_sy[1];
    assign sel_s    = s_r.sel_sy[1];

    // half period = (pre+1) * 2^sel, so a full period matches the divisor
    assign half_per = (CNT_W'(s_r.div[PRE_LSB+2:PRE_LSB]) + CNT_W'(1))
                      << s_r.div[2:0];
    // half period tick; a slave steps on synced edges
    assign tick     = (s_r.tick_cnt == half_per - CNT_W'(1));
    assign sl_edge  = (sck_s != s_r.sck_d);
    assign step     = master ? tick : sl_edge;
    assign sample   = (s_r.edge_cnt[0] == clock_phase);
    assign rbit     = master ? s_r.miso_sy[1] : s_r.mosi_sy[1];
    assign w_ctrl1  = wr_stb && (addr == OFS_CTRL1);
    assign w_data   = wr_stb && (addr == OFS_DATA);
    assign wd       = wdata;

    // conditions that drop a running byte and return to idle
    always_comb
    begin
        abort = !sys_en;
        if (w_ctrl1 && (wd[B_MASTER] != master))
            abort = 1'b1;
        if (w_ctrl1 && master && ((wd[B_CLOCK_POLARITY] != clock_polarity) || (wd[B_CLOCK_PHASE] != clock_phase)
            || (wd[B_SEL_OE] != sel_oe) || (wd[B_LSB_FIRST] != lsb)))
            abort = 1'b1;
        // divider and fault enable changes abort too
        if (wr_stb && master && (addr == OFS_CTRL2)
            && (wd[B_FAULT_EN] != fault_en))
            abort = 1'b1;
        if (wr_stb && master && (addr == OFS_DIV) && ((wd & DIV_MASK) != s_r.div))
            abort = 1'b1;
        // slave deselected mid byte
        if (!master && sel_s)
            abort = 1'b1;
        if (master && fault_en && !sel_oe && !sel_s)
            abort = 1'b1;
    end

    // whole next state
    always_comb
    begin
        s_nxt = s_r;
        ev_set = '0;
        s_nxt.sck_sy  = {s_r.sck_sy[0], sck_in};
        s_nxt.mosi_sy = {s_r.mosi_sy[0], mosi_in};
        s_nxt.miso_sy = {s_r.miso_sy[0], miso_in};
        s_nxt.sel_sy  = {s_r.sel_sy[0], sel_in};
        s_nxt.sck_d   = sck_s;

        // register writes; status and reserved offsets have no case
        if (wr_stb)
        begin
            unique case (addr)
                OFS_CTRL1: s_nxt.ctrl1 = wd;
                OFS_CTRL2: s_nxt.ctrl2 = wd & CTRL2_MASK;
                OFS_DIV:   s_nxt.div   = wd & DIV_MASK;
                OFS_DATA:  s_nxt.tx_buf = wd;
                OFS_EVENT: s_nxt.ev    = s_r.ev & ~wd[EV_W-1:0];
                OFS_MASK:  s_nxt.mask  = wd[EV_W-1:0];
                default:   s_nxt.mask  = s_nxt.mask;
            endcase
        end

        // flag clearing: status read arms, data access or control write clears
        if (rd_stb && (addr == OFS_STATUS))
        begin
            s_nxt.st_seen_done  = s_r.done;
            s_nxt.st_seen_empty = s_r.empty;
            s_nxt.st_seen_fault = s_r.fault;
        end
        if (rd_stb && (addr == OFS_DATA) && s_r.st_seen_done)
        begin
            s_nxt.done = 1'b0;
            s_nxt.st_seen_done = 1'b0;
        end
        if (w_data && s_r.st_seen_empty)
        begin
            s_nxt.empty = 1'b0;
            s_nxt.st_seen_empty = 1'b0;
        end
        if (w_ctrl1 && s_r.st_seen_fault)
        begin
            s_nxt.fault = 1'b0;
            s_nxt.st_seen_fault = 1'b0;
        end

        // shifter
        if (abort)
        begin
            s_nxt.ph = IDLE;
            s_nxt.edge_cnt = '0;
            s_nxt.tick_cnt = '0;
            // fault: listening master sees select low
            if (master && fault_en && !sel_oe && !sel_s && sys_en)
            begin
                s_nxt.fault = 1'b1;
                ev_set[E_FAULT] = 1'b1;
            end
        end
        else
        begin
            unique case (s_r.ph)
                IDLE:
                begin
                    s_nxt.tick_cnt = '0;
                    s_nxt.edge_cnt = '0;
                    // master needs data, slave a low select
                    if ((master && !s_r.empty) || (!master && !sel_s))
                    begin
                        s_nxt.ph = RUN;
                        s_nxt.tx_sh = master ? s_r.tx_buf : s_r.tx_sh;
                        if (master || !s_r.empty)
                        begin
                            s_nxt.tx_sh = s_r.tx_buf;
                            s_nxt.empty = 1'b1;
                            ev_set[E_EMPTY] = 1'b1;
                        end
                        if (!clock_phase)
                        begin
                            s_nxt.dout  = first_bit(s_nxt.tx_sh, lsb);
                            s_nxt.tx_sh = shift_out(s_nxt.tx_sh, lsb);
                        end
                    end
                end
                RUN:
                begin
                    s_nxt.tick_cnt = tick ? '0 : s_r.tick_cnt + CNT_W'(1);
                    if (step)
                    begin
                        s_nxt.edge_cnt = s_r.edge_cnt + 4'h1;
                        if (sample)
                            s_nxt.rx_sh = shift_in(s_r.rx_sh, rbit, lsb);
                        else if (s_r.edge_cnt != LAST_EDGE)
                        begin
                            s_nxt.dout  = first_bit(s_r.tx_sh, lsb);
                            s_nxt.tx_sh = shift_out(s_r.tx_sh, lsb);
                        end
                        // last edge closes the byte
                        if (s_r.edge_cnt == LAST_EDGE)
                        begin
                            s_nxt.ph = IDLE;
                            s_nxt.rx_data = sample ?
                                shift_in(s_r.rx_sh, rbit, lsb) : s_r.rx_sh;
                            s_nxt.done = 1'b1;
                            ev_set[E_DONE] = 1'b1;
                        end
                    end
                end
            endcase
        end
        s_nxt.ev = s_nxt.ev | ev_set;

        // disabled block holds flags at their reset values
        if (!sys_en)
        begin
            s_nxt.done  = 1'b0;
            s_nxt.fault = 1'b0;
            s_nxt.empty = 1'b1;
            s_nxt.st_seen_done  = 1'b0;
            s_nxt.st_seen_empty = 1'b0;
            s_nxt.st_seen_fault = 1'b0;
        end

        // master clock: idle level from polarity, toggles per half period
        if (master && s_nxt.ph == RUN)
            s_nxt.sck_r = (s_r.ph == RUN && tick) ? ~s_r.sck_r : s_r.sck_r;
        else
            s_nxt.sck_r = s_nxt.ctrl1[B_CLOCK_POLARITY];

        // pin direction
        s_nxt.sck_oe_r  = !(sys_en && master);
        s_nxt.mosi_oe_r = !(sys_en && master);
        s_nxt.miso_oe_r = !(sys_en && !master && !sel_s);
        s_nxt.mosi_r    = s_nxt.dout;
        s_nxt.miso_r    = s_nxt.dout;
        s_nxt.sel_oe_r  = !(sys_en && master && fault_en && sel_oe);
        s_nxt.sel_r     = !(s_nxt.ph == RUN);

        // interrupt: documented enables plus masked sticky events
        s_nxt.irq_r = (s_nxt.ctrl1[B_IRQ_EN] && (s_nxt.done || s_nxt.fault))
                    || (s_nxt.ctrl1[B_TXE_IRQ_EN] && s_nxt.empty)
                    || |(s_nxt.ev & s_nxt.mask);

        // read data one cycle after the strobe
        s_nxt.rdata_r = 8'h00;
        if (rd_stb)
        begin
            unique case (addr)
                OFS_CTRL1:  s_nxt.rdata_r = s_r.ctrl1;
                OFS_CTRL2:  s_nxt.rdata_r = s_r.ctrl2;
                OFS_DIV:    s_nxt.rdata_r = s_r.div;
                OFS_STATUS: s_nxt.rdata_r = {s_r.done, 1'b0, s_r.empty, s_r.fault,
                                             4'h0};
                OFS_DATA:   s_nxt.rdata_r = s_r.rx_data;
                OFS_EVENT:  s_nxt.rdata_r = {5'h00, s_r.ev};
                OFS_MASK:   s_nxt.rdata_r = {5'h00, s_r.mask};
                default:    s_nxt.rdata_r = 8'h00;
            endcase
        end
    end

    // state register
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            // all else starts at zero
            s_r           <= '0;
            s_r.ctrl1     <= RST_CTRL1;
            s_r.ctrl2     <= RST_CTRL2;
            s_r.div       <= RST_DIV;
            s_r.empty     <= 1'b1;
            s_r.ph        <= IDLE;
            s_r.sck_oe_r  <= 1'b1;
            s_r.mosi_oe_r <= 1'b1;
            s_r.miso_oe_r <= 1'b1;
            s_r.sel_oe_r  <= 1'b1;
            s_r.sel_r     <= 1'b1;
            s_r.sel_sy    <= 2'b11;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    // outputs straight from the state register
    assign rdata     = s_r.rdata_r;
    assign irq       = s_r.irq_r;
    assign sck_out   = s_r.sck_r;
    assign sck_oe_n  = s_r.sck_oe_r;
    assign mosi_out  = s_r.mosi_r;
    assign mosi_oe_n = s_r.mosi_oe_r;
    assign miso_out  = s_r.miso_r;
    assign miso_oe_n = s_r.miso_oe_r;
    assign sel_out   = s_r.sel_r;
    assign sel_oe_n  = s_r.sel_oe_r;

endmodule : spi_fe

// ---- verification/spi_fe_props.sv ----
// Purpose: port level checks of the serial link front end
// Assumes: one clock domain, async active low reset
// Notes:   polarity is tracked from writes to control one
`timescale 1ns/1ps
module spi_fe_props
    import spi_fe_pkg::*;
(
    input wire logic              sys_clk,
    input wire logic              nrst,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [7:0]        wdata,
    input wire logic              wr_stb,
    input wire logic              rd_stb,
    input wire logic [7:0]        rdata,
    input wire logic              sck_out,
    input wire logic              sck_oe_n,
    input wire logic              mosi_oe_n,
    input wire logic              miso_oe_n,
    input wire logic              sel_out,
    input wire logic              sel_oe_n
);
    logic pol_r;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    // shadow of the clock polarity bit
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
            pol_r <= RST_CTRL1[B_CLOCK_POLARITY];
        else if (wr_stb && addr == OFS_CTRL1)
            pol_r <= wdata[B_CLOCK_POLARITY];
    end
    // read data and reserved places
    a_read_idle_zero: assert property (
        !$past(rd_stb) |-> rdata == 8'h00) else $error("read data not zero");
    a_rsvd_read_zero: assert property (
        rd_stb && addr inside {4'h4, 4'h6, 4'h7} |=> rdata == 8'h00)
        else $error("reserved read not zero");
    a_status_rsvd_zero: assert property (
        rd_stb && addr == OFS_STATUS |=> (rdata & 8'h4f) == 8'h00)
        else $error("status spare bits set");
    a_ctrl2_rsvd_zero: assert property (
        rd_stb && addr == OFS_CTRL2 |=> (rdata & ~CTRL2_MASK) == 8'h00)
        else $error("control two spare bits set");
    a_div_rsvd_zero: assert property (
        rd_stb && addr == OFS_DIV |=> (rdata & ~DIV_MASK) == 8'h00)
        else $error("divider spare bits set");
    // pin ownership
    a_sel_oe_master: assert property (
        !sel_oe_n |-> !sck_oe_n) else $error("select driven outside master");
    a_miso_oe_slave: assert property (
        !miso_oe_n |-> sck_oe_n) else $error("miso driven in master");
    a_mosi_sck_oe: assert property (
        mosi_oe_n == sck_oe_n) else $error("mosi and sck enables differ");
    a_sck_idle_level: assert property (
        (sel_out && !sck_oe_n && pol_r == $past(pol_r, 3)) [*3] |-> sck_out == pol_r)
        else $error("idle clock level wrong");
endmodule : spi_fe_props

bind spi_fe spi_fe_props u_spi_fe_props (
    .sys_clk(sys_clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
    .rd_stb(rd_stb), .rdata(rdata), .sck_out(sck_out), .sck_oe_n(sck_oe_n),
    .mosi_oe_n(mosi_oe_n), .miso_oe_n(miso_oe_n), .sel_out(sel_out), .sel_oe_n(sel_oe_n));

// ---- verification/spi_fe_tb.sv ----
// Purpose: self checking bench of the serial link front end
// Assumes: slave model on the link, select line pulled high
// Notes:   divider 0x12 gives a half period of eight cycles
`timescale 1ns/1ps
module spi_fe_tb;
    import spi_fe_pkg::*;
    logic              sys_clk = 1'b0;
    logic              nrst    = 1'b0;
    logic [ADDR_W-1:0] addr    = '0;
    logic [7:0]        wdata   = 8'h00;
    logic              wr_stb  = 1'b0;
    logic              rd_stb  = 1'b0;
    logic              sel_drv = 1'b1;
    logic              s_sck   = 1'b0;
    logic              s_mosi  = 1'b0;
    logic              m_pha   = 1'b0;
    logic              m_lsb   = 1'b0;
    logic [7:0]        m_tx    = 8'h00;
    logic [7:0]        rdata, m_rx;
    logic              irq, sck_out, sck_oe_n, mosi_out, mosi_oe_n, miso_out;
    logic              miso_oe_n, sel_out, sel_oe_n, m_miso, sel_line;
    int                num_errors = 0;
    int                n_checks   = 0;
    // clock and select line with pull-up
    always #2.5 sys_clk = ~sys_clk;
    assign sel_line = sel_oe_n ? sel_drv : sel_out;
    spi_fe u_spi_fe (.sys_clk(sys_clk), .nrst(nrst), .addr(addr), .wdata(wdata),
        .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .irq(irq), .sck_in(s_sck),
        .sck_out(sck_out), .sck_oe_n(sck_oe_n), .mosi_in(s_mosi), .mosi_out(mosi_out),
        .mosi_oe_n(mosi_oe_n), .miso_in(m_miso), .miso_out(miso_out),
        .miso_oe_n(miso_oe_n), .sel_in(sel_line), .sel_out(sel_out), .sel_oe_n(sel_oe_n));
    spi_slave_model u_spi_slave_model (.sys_clk(sys_clk), .sck(sck_out), .mosi(mosi_out),
        .sel_n(sel_line), .pha(m_pha), .lsb(m_lsb), .tx_byte(m_tx), .miso(m_miso),
        .rx_byte(m_rx));
    task automatic tally_and_finish;
        if (num_errors == 0 && n_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : tally_and_finish
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        addr   <= a;
        wdata  <= d;
        wr_stb <= 1'b1;
        @(posedge sys_clk);
        wr_stb <= 1'b0;
    endtask : wr
    task automatic rd(input logic [ADDR_W-1:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        addr   <= a;
        rd_stb <= 1'b1;
        @(posedge sys_clk);
        rd_stb <= 1'b0;
        #1 d = rdata;
    endtask : rd
    task automatic settle;
        repeat (2) @(posedge sys_clk);
        #1;
    endtask : settle
    task automatic t_reset;
        logic [7:0] d;
        logic [3:0] a [6] = '{OFS_CTRL1, OFS_CTRL2, OFS_DIV, OFS_STATUS, OFS_EVENT, OFS_MASK};
        logic [7:0] e [6] = '{RST_CTRL1, RST_CTRL2, RST_DIV, 8'h20, 8'h00, 8'h00};
        for (int j = 0; j < 6; j++)
        begin
            rd(a[j], d);
            chk("reset value", d, e[j]);
        end
    endtask : t_reset
    task automatic t_regs;
        logic [7:0] d;
        logic [3:0] r [4] = '{4'h4, 4'h6, 4'h7, 4'hc};
        wr(OFS_CTRL1, 8'haf);
        rd(OFS_CTRL1, d);
        chk("control one", d, 8'haf);
        chk("empty irq on", {7'h00, irq}, 8'h01);
        wr(OFS_CTRL1, 8'h8f);
        settle();
        chk("empty irq off", {7'h00, irq}, 8'h00);
        wr(OFS_CTRL2, 8'hff);
        rd(OFS_CTRL2, d);
        chk("control two", d, 8'h1b);
        wr(OFS_DIV, 8'hff);
        rd(OFS_DIV, d);
        chk("divider", d, 8'h77);
        wr(OFS_STATUS, 8'hff);
        rd(OFS_STATUS, d);
        chk("status write", d, 8'h20);
        for (int j = 0; j < 4; j++)
        begin
            wr(r[j], 8'hff);
            rd(r[j], d);
            chk("reserved", d, 8'h00);
        end
    endtask : t_regs
    task automatic wait_done(output logic [7:0] s);
        for (int k = 0; k < 100; k++)
        begin
            rd(OFS_STATUS, s);
            if (s[B_DONE] === 1'b1)
                break;
        end
        chk("status done", s, 8'ha0);
    endtask : wait_done
    task automatic t_xfer(input int i);
        logic [7:0] s, tx;
        logic       v;
        int         k;
        tx = 8'h1d ^ 8'(i);
        m_tx  <= 8'hb2 ^ 8'(i);
        m_pha <= i[0];
        m_lsb <= i[0];
        wr(OFS_DIV, 8'h12);
        wr(OFS_CTRL2, 8'h10);
        wr(OFS_CTRL1, {(i == 2), 3'b101, i[1:0], 1'b1, i[0]});
        rd(OFS_STATUS, s);
        wr(OFS_DATA, tx);
        for (int h = 0; h < 2; h++)
        begin
            v = sck_out;
            k = 0;
            while (sck_out === v && k < 100)
            begin
                @(posedge sys_clk);
                #1 k++;
            end
        end
        chk("half period", 8'(k), 8'h08);
        wait_done(s);
        chk("done irq", {7'h00, irq}, {7'h00, (i == 2)});
        rd(OFS_DATA, s);
        chk("received", s, 8'hb2 ^ 8'(i));
        chk("sent", m_rx, tx);
    endtask : t_xfer
    task automatic t_events;
        logic [7:0] d;
        rd(OFS_EVENT, d);
        chk("events", d, 8'h03);
        wr(OFS_MASK, 8'h01);
        settle();
        chk("masked irq", {7'h00, irq}, 8'h01);
        wr(OFS_EVENT, 8'h01);
        settle();
        chk("cleared irq", {7'h00, irq}, 8'h00);
        rd(OFS_EVENT, d);
        chk("events left", d, 8'h02);
        wr(OFS_MASK, 8'h00);
        wr(OFS_EVENT, 8'h02);
    endtask : t_events
    task automatic t_abort;
        logic [7:0] s;
        wr(OFS_CTRL1, 8'h52);
        rd(OFS_STATUS, s);
        wr(OFS_DATA, 8'h5a);
        repeat (40) @(posedge sys_clk);
        wr(OFS_CTRL1, 8'h53);
        repeat (150) @(posedge sys_clk);
        rd(OFS_STATUS, s);
        chk("aborted status", s, 8'h20);
        chk("select idle", {7'h00, sel_out}, 8'h01);
        wr(OFS_CTRL1, 8'h12);
        rd(OFS_STATUS, s);
        chk("disabled status", s, 8'h20);
        chk("sck released", {7'h00, sck_oe_n}, 8'h01);
    endtask : t_abort
    task automatic t_fault;
        logic [7:0] s;
        @(posedge sys_clk) sel_drv <= 1'b0;
        wr(OFS_CTRL2, 8'h10);
        wr(OFS_CTRL1, 8'hd0);
        repeat (6) @(posedge sys_clk);
        rd(OFS_STATUS, s);
        chk("fault status", s, 8'h30);
        chk("fault irq", {7'h00, irq}, 8'h01);
        chk("select input", {7'h00, sel_oe_n}, 8'h01);
        @(posedge sys_clk) sel_drv <= 1'b1;
        rd(OFS_STATUS, s);
        wr(OFS_CTRL1, 8'h50);
        rd(OFS_STATUS, s);
        chk("fault cleared", s, 8'h20);
        wr(OFS_CTRL1, 8'h42);
        sel_drv <= 1'b0;
        repeat (6) @(posedge sys_clk);
        #1 chk("slave select in", {7'h00, sel_oe_n}, 8'h01);
        chk("slave drives", {7'h00, miso_oe_n}, 8'h00);
        @(posedge sys_clk) sel_drv <= 1'b1;
    endtask : t_fault
    task automatic t_slave;
        logic [7:0] s, got;
        logic [7:0] pat = 8'ha5;
        wr(OFS_CTRL1, 8'h40);
        rd(OFS_STATUS, s);
        wr(OFS_DATA, 8'h6c);
        sel_drv <= 1'b0;
        s_mosi  <= pat[7];
        repeat (6) @(posedge sys_clk);
        for (int b = 0; b < 16; b++)
        begin
            if (!b[0])
                got[7 - b / 2] = miso_out;
            else if (b < 15)
                s_mosi <= pat[6 - b / 2];
            s_sck <= ~s_sck;
            repeat (6) @(posedge sys_clk);
        end
        rd(OFS_STATUS, s);
        chk("slave status", s, 8'ha0);
        rd(OFS_DATA, s);
        chk("slave received", s, 8'ha5);
        chk("slave sent", got, 8'h6c);
    endtask : t_slave
    // main sequence
    initial
    begin
        repeat (16) @(posedge sys_clk);
        nrst <= 1'b1;
        t_reset();
        t_regs();
        for (int i = 0; i < 4; i++)
            t_xfer(i);
        t_events();
        t_abort();
        t_fault();
        t_slave();
        tally_and_finish();
    end
    // watchdog against a hang
    initial
    begin
        #100000;
        num_errors++;
        tally_and_finish();
    end
endmodule : spi_fe_tb

// ---- verification/spi_slave_model.sv ----
// Purpose: remote serial slave facing the front end in master mode
// Assumes: clock and select are sampled with sys_clk
// Notes:   a released miso toggles each cycle so stale bits never match
`timescale 1ns/1ps
module spi_slave_model (
    input  wire logic       sys_clk,
    input  wire logic       sck,
    input  wire logic       mosi,
    input  wire logic       sel_n,
    input  wire logic       pha,
    input  wire logic       lsb,
    input  wire logic [7:0] tx_byte,
    output logic            miso,
    output logic [7:0]      rx_byte
);
    logic       sck_d;
    logic       sel_d;
    logic [4:0] n;
    logic [2:0] k;
    initial miso = 1'b0;
    // edge count, sampling and shifting of one byte
    always @(posedge sys_clk)
    begin
        sck_d <= sck;
        sel_d <= sel_n;
        k = n[3:1] + {2'b00, ~pha};
        if (sel_n)
        begin
            n    <= 5'h00;
            miso <= ~miso;
        end
        else if (sel_d && !pha)
            miso <= tx_byte[lsb ? 0 : 7];
        else if (sck != sck_d)
        begin
            n <= n + 5'h01;
            if (n[0] == pha)
                rx_byte[lsb ? n[3:1] : 3'h7 - n[3:1]] <= mosi;
            else
                miso <= tx_byte[lsb ? k : 3'h7 - k];
        end
    end
endmodule : spi_slave_model
